// *** design/cod_decoder.sv ***
/*
 * Operand and instruction decoder for a subset of an 8-bit CPU.
 * Assumes fetch presents one instruction per instr_valid pulse with its
 * operand values already read; execution writes result when wr_en is high.
 */
`timescale 1ns/1ns
module cod_decoder
   import cod_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Instruction from fetch
   input wire logic instr_valid,
   input wire logic [7:0] opcode,
   input wire logic [ADDR_W-1:0] next_pc,
   input wire logic [7:0] disp,
   input wire logic [ADDR_W-1:0] index_base,
   input wire logic [3:0] wpair_idx,
   input wire logic [7:0] fpair_reg,
   input wire logic [7:0] vector_val,
   input wire logic branch_taken,
   input wire logic [7:0] dst_val,
   input wire logic [7:0] src_val,
   input wire logic [7:0] flags_in,
   // Result to datapath
   output logic wr_en,
   output logic [7:0] wr_data,
   output logic [7:0] flags_out,
   output logic [ADDR_W-1:0] branch_target,
   output logic branch_en,
   output logic [ADDR_W-1:0] index_addr,
   output logic wpair_ok,
   output logic fpair_ok,
   output logic vector_ok,
   output logic [2:0] op_class,
   // Request blocking
   output logic irq_dma_block
);
   // ****************************************
   // Decode helpers
   // ****************************************
   function automatic logic in_range(input logic [7:0] op, input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (op >= lo) && (op <= hi);
   endfunction : in_range

   function automatic logic [ADDR_W-1:0] sext_add(input logic [ADDR_W-1:0] base,
                                                  input logic [7:0] off);
      sext_add = base + {{(ADDR_W-8){off[7]}}, off};
   endfunction : sext_add

   cod_ex_if ex ();
   cod_adder u_adder (.ex(ex));
   assign ex.dst_val = dst_val;
   assign ex.src_val = src_val;

   cod_class_e cls;
   logic [7:0] and_res;
   logic [2:0] atomic_left;

   always_comb begin
      if (in_range(opcode, OP_ADD_LO, OP_ADD_HI) || in_range(opcode, OP_ADDX_LO, OP_ADDX_HI)) begin
         cls = COD_OP_ADD;
      end else if (in_range(opcode, OP_AND_LO, OP_AND_HI)) begin
         cls = COD_OP_AND;
      end else if (opcode == OP_ATOMIC) begin
         cls = COD_OP_ATOMIC;
      end else if (in_range(opcode, OP_BTB_LO, OP_BTB_HI)) begin
         cls = COD_OP_BRANCH;
      end else if (opcode == OP_BRK || opcode == OP_BITOP || opcode == OP_BIT_REVERSE) begin
         cls = COD_OP_OTHER;
      end else begin
         cls = COD_OP_NONE;
      end
   end

   assign and_res = dst_val & src_val;

   // ****************************************
   // Write-back and flags
   // ****************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_en <= 1'b0;
         wr_data <= 8'h00;
         flags_out <= 8'h00;
         op_class <= 3'h0;
      end else begin
         wr_en <= instr_valid && (cls == COD_OP_ADD || cls == COD_OP_AND);
         op_class <= instr_valid ? 3'(cls) : 3'(COD_OP_NONE);
         if (instr_valid && cls == COD_OP_ADD) begin
            wr_data <= ex.sum;
            flags_out <= flags_in;
            flags_out[FLAG_C] <= ex.carry;
            flags_out[FLAG_Z] <= (ex.sum == 8'h00);
            flags_out[FLAG_S] <= ex.sum[7];
            flags_out[FLAG_V] <= ex.ovf;
            flags_out[FLAG_D] <= 1'b0;
            flags_out[FLAG_H] <= ex.half;
         end else if (instr_valid && cls == COD_OP_AND) begin
            wr_data <= and_res;
            flags_out <= flags_in; // Keeps C, D, H
            flags_out[FLAG_Z] <= (and_res == 8'h00);
            flags_out[FLAG_S] <= and_res[7];
            flags_out[FLAG_V] <= 1'b0;
         end
      end
   end

   // ****************************************
   // Addressing
   // ****************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         branch_target <= '0;
         branch_en <= 1'b0;
         index_addr <= '0;
         wpair_ok <= 1'b0;
         fpair_ok <= 1'b0;
         vector_ok <= 1'b0;
      end else begin
         branch_target <= sext_add(next_pc, disp);
         branch_en <= instr_valid && cls == COD_OP_BRANCH && branch_taken;
         index_addr <= sext_add(index_base, disp);
         wpair_ok <= instr_valid && !wpair_idx[0] && (wpair_idx <= WPAIR_MAX);
         fpair_ok <= instr_valid && !fpair_reg[0] && (fpair_reg <= FPAIR_MAX);
         vector_ok <= instr_valid && (vector_val <= VECTOR_MAX);
      end
   end

   // ****************************************
   // Atomic sequence blocking
   // ****************************************
   // Counts following instructions; a fresh atomic opcode restarts the window
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         atomic_left <= 3'h0;
      end else if (instr_valid && cls == COD_OP_ATOMIC) begin
         atomic_left <= ATOMIC_LEN;
      end else if (instr_valid && atomic_left != 3'h0) begin
         atomic_left <= atomic_left - 3'h1;
      end
   end
   assign irq_dma_block = (atomic_left != 3'h0);

   // ****************************************
   // Checks
   // ****************************************
   a_add_writeback: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid && in_range(opcode, OP_ADD_LO, OP_ADD_HI)
      |=> wr_en && wr_data == 8'($past(dst_val) + $past(src_val)))
      else $error("add result not written back");
   a_branch_target: assert property (@(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> branch_target == sext_add($past(next_pc), $past(disp)))
      else $error("branch target wrong");
   a_index_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> index_addr == sext_add($past(index_base), $past(disp)))
      else $error("indexed address wrong");
   a_wpair_odd: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wpair_idx[0] |=> !wpair_ok)
      else $error("odd working pair accepted");
   a_fpair_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid |=> fpair_ok == !$past(fpair_reg[0]))
      else $error("full pair check wrong");
   a_vector_any: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid |=> vector_ok)
      else $error("vector rejected");
   a_atomic_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid && opcode == OP_ATOMIC |=> irq_dma_block && atomic_left == ATOMIC_LEN)
      else $error("atomic did not block");
   a_and_flags: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid && in_range(opcode, OP_AND_LO, OP_AND_HI)
      |=> !flags_out[FLAG_V] && flags_out[FLAG_C] == $past(flags_in[FLAG_C])
          && flags_out[FLAG_H] == $past(flags_in[FLAG_H]))
      else $error("and flags wrong");
   // Acceptances, refusals, idle outputs, add flags, AND results and flags, and the hold and end of the atomic window
   a_wpair_even: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid && !wpair_idx[0] |=> wpair_ok)
      else $error("even working pair refused");
   a_branch_en: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid && in_range(opcode, OP_BTB_LO, OP_BTB_HI)
      |=> branch_en == $past(branch_taken))
      else $error("branch enable wrong");
   a_refused_op: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid && cls == COD_OP_NONE |=> !wr_en && !branch_en && op_class == 3'h0)
      else $error("unknown opcode acted on");
   // Pulses stand only in the cycle after a taken instruction
   a_idle_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !instr_valid |=> !wr_en && !branch_en && !wpair_ok && !fpair_ok && !vector_ok)
      else $error("result pulse without instruction");
   a_add_flags: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid && in_range(opcode, OP_ADD_LO, OP_ADD_HI)
      |=> !flags_out[FLAG_D] && flags_out[FLAG_Z] == (wr_data == 8'h00))
      else $error("add flags wrong");
   a_and_result: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid && in_range(opcode, OP_AND_LO, OP_AND_HI)
      |=> wr_en && wr_data == ($past(dst_val) & $past(src_val))
          && flags_out[FLAG_Z] == (wr_data == 8'h00) && flags_out[FLAG_S] == wr_data[7])
      else $error("and result wrong");
   a_and_keep_d: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid && in_range(opcode, OP_AND_LO, OP_AND_HI) |=> flags_out[FLAG_D] == $past(flags_in[FLAG_D]))
      else $error("and changed decimal adjust");
   a_block_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      irq_dma_block && !instr_valid |=> irq_dma_block)
      else $error("block dropped without instruction");
   // Last instruction of the window must lift the block on the next edge
   a_block_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
      instr_valid && opcode != OP_ATOMIC && atomic_left == 3'h1 |=> !irq_dma_block)
      else $error("block held past window");
   c_other: cover property (@(posedge sys_clk) instr_valid && cls == COD_OP_OTHER);
   c_add: cover property (@(posedge sys_clk) instr_valid && cls == COD_OP_ADD);
   c_and: cover property (@(posedge sys_clk) instr_valid && cls == COD_OP_AND);
   c_atomic_end: cover property (@(posedge sys_clk) $fell(irq_dma_block));
   c_branch: cover property (@(posedge sys_clk) branch_en);
endmodule : cod_decoder

// *** design/cod_pkg.sv ***
/*
 * Shared constants for the operand decoder: opcodes, ranges, flag positions.
 * Assumes a single system clock and an 8-bit instruction stream.
 */
package cod_pkg;
   // ****************************************
   // Opcodes
   // ****************************************
   localparam logic [7:0] OP_BRK = 8'h00;
   localparam logic [7:0] OP_ADD_LO = 8'h02;
   localparam logic [7:0] OP_ADD_HI = 8'h07;
   localparam logic [7:0] OP_ADDX_LO = 8'h08;
   localparam logic [7:0] OP_ADDX_HI = 8'h09;
   localparam logic [7:0] OP_ATOMIC = 8'h2f;
   localparam logic [7:0] OP_AND_LO = 8'h52;
   localparam logic [7:0] OP_AND_HI = 8'h59;
   localparam logic [7:0] OP_BITOP = 8'he2;
   localparam logic [7:0] OP_BIT_REVERSE = 8'hd5;
   localparam logic [7:0] OP_BTB_LO = 8'hf6;
   localparam logic [7:0] OP_BTB_HI = 8'hf7;
   // ****************************************
   // Operand ranges and timing
   // ****************************************
   localparam logic [3:0] WPAIR_MAX = 4'he;
   localparam logic [7:0] FPAIR_MAX = 8'hfe;
   localparam logic [7:0] VECTOR_MAX = 8'hff;
   localparam logic [2:0] ATOMIC_LEN = 3'h3;
   // ****************************************
   // Flag bit positions in the flags byte
   // ****************************************
   localparam int FLAG_C = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 5;
   localparam int FLAG_V = 4;
   localparam int FLAG_D = 3;
   localparam int FLAG_H = 2;

   typedef enum logic [2:0] {
      COD_OP_NONE,
      COD_OP_ADD,
      COD_OP_AND,
      COD_OP_ATOMIC,
      COD_OP_BRANCH,
      COD_OP_OTHER
   } cod_class_e;
endpackage : cod_pkg

// *** design/cod_ex_if.sv ***
/*
 * Interface carrying the operand values from decoder to adder helper, and sum, carry, half and overflow back.
 * Assumes both ends share sys_clk.
 */
`timescale 1ns/1ns
interface cod_ex_if;
   logic [7:0] dst_val;
   logic [7:0] src_val;
   logic [7:0] sum;
   logic carry;
   logic half;
   logic ovf;
   modport core (output dst_val, output src_val, input sum, input carry, input half, input ovf);
   modport alu (input dst_val, input src_val, output sum, output carry, output half, output ovf);
endinterface : cod_ex_if

// *** design/cod_adder.sv ***
/*
 * Combinational 8-bit adder with carry, half-carry and signed overflow.
 * Assumes the decoder registers its result.
 */
`timescale 1ns/1ns
module cod_adder
   import cod_pkg::*;
(
   // Operand link
   cod_ex_if.alu ex
);
   logic [8:0] full;
   logic [4:0] low;

   assign full = {1'b0, ex.dst_val} + {1'b0, ex.src_val};
   assign low = {1'b0, ex.dst_val[3:0]} + {1'b0, ex.src_val[3:0]};
   assign ex.sum = full[7:0];
   assign ex.carry = full[8];
   assign ex.half = low[4];
   // Overflow when like-signed operands give an unlike-signed sum
   assign ex.ovf = (ex.dst_val[7] == ex.src_val[7]) && (full[7] != ex.dst_val[7]);
endmodule : cod_adder

// *** testbench/cod_dp_model.sv ***
/* Execution datapath model holding the destination byte.
   Assumes wr_en from the decoder is high for one cycle per write-back instruction, so it stays high across back-to-back ones. */
`timescale 1ns/1ns
module cod_dp_model
   import cod_pkg::*;
(
   // Clock and write port
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   // Stored destination
   output logic [7:0] dst_loc
);
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         dst_loc <= wr_data;
      end
   end
endmodule : cod_dp_model

// *** testbench/tb_top.sv ***
/* Self-checking bench for the operand decoder with a scoreboard queue.
   Assumes every result appears one cycle after its instruction. */
`timescale 1ns/1ns
module tb_top
   import cod_pkg::*;
;
   typedef struct {logic we, be, wo, fo, blk; logic [7:0] wd, fl; logic [2:0] cl;
      logic [15:0] bt, ia;} cod_exp_s;
   logic sys_clk = 0, sys_rst = 1, instr_valid = 0, branch_taken = 0;
   logic [7:0] opcode = 0, disp = 0, fpair_reg = 0, vector_val = 0;
   logic [7:0] dst_val = 0, src_val = 0, flags_in = 0, wb_exp, wr_data, flags_out, dst_loc;
   logic [15:0] next_pc = 0, index_base = 0, branch_target, index_addr;
   logic [3:0] wpair_idx = 0;
   logic [2:0] op_class;
   logic wr_en, branch_en, wpair_ok, fpair_ok, vector_ok, irq_dma_block;
   logic pend = 0, wb_pend = 0;
   logic [10:0] junk;
   logic [31:0] r;
   int err_count = 0, compares = 0, seed = 67942, rem = 0;
   cod_exp_s q[$];
   cod_exp_s m;

   always #4 sys_clk = ~sys_clk;

   cod_decoder dut (.sys_clk, .sys_rst, .instr_valid, .opcode, .next_pc, .disp,
      .index_base, .wpair_idx, .fpair_reg, .vector_val, .branch_taken, .dst_val,
      .src_val, .flags_in, .wr_en, .wr_data, .flags_out, .branch_target, .branch_en,
      .index_addr, .wpair_ok, .fpair_ok, .vector_ok, .op_class, .irq_dma_block);
   cod_dp_model dp (.sys_clk, .wr_en, .wr_data, .dst_loc);

   // ****************************************
   // Driver with expectation model
   // ****************************************
   task automatic send(logic [7:0] op, logic [8:0] d);
      cod_exp_s e;
      logic [8:0] s;
      logic [4:0] h;
      @(negedge sys_clk);
      instr_valid = 1;
      opcode = op;
      {dst_val, src_val, flags_in, fpair_reg} = $random(seed);
      {next_pc, index_base} = $random(seed);
      {vector_val, disp, wpair_idx, branch_taken, junk} = $random(seed);
      if (!d[8]) begin
         disp = d[7:0];
      end
      s = {1'b0, dst_val} + {1'b0, src_val};
      h = {1'b0, dst_val[3:0]} + {1'b0, src_val[3:0]};
      e.cl = (op inside {[OP_ADD_LO:OP_ADDX_HI]}) ? 3'h1 : (op inside {[OP_AND_LO:OP_AND_HI]})
         ? 3'h2 : (op == OP_ATOMIC) ? 3'h3 : (op inside {OP_BTB_LO, OP_BTB_HI}) ? 3'h4
         : (op inside {OP_BRK, OP_BITOP, OP_BIT_REVERSE}) ? 3'h5 : 3'h0;
      e.we = e.cl inside {3'h1, 3'h2};
      e.wd = (e.cl == 3'h1) ? s[7:0] : dst_val & src_val;
      e.fl = (e.cl == 3'h1) ? {s[8], s[7:0] == 8'h00, s[7],
         dst_val[7] == src_val[7] && s[7] != dst_val[7], 1'b0, h[4], 2'h0}
         : {flags_in[7], e.wd == 8'h00, e.wd[7], 1'b0, flags_in[3:2], 2'h0};
      e.bt = next_pc + {{8{disp[7]}}, disp};
      e.ia = index_base + {{8{disp[7]}}, disp};
      e.be = (e.cl == 3'h4) && branch_taken;
      e.wo = !wpair_idx[0];
      e.fo = !fpair_reg[0];
      // A second atomic inside the window restarts the count
      rem = (op == OP_ATOMIC) ? 3 : (rem > 0) ? rem - 1 : 0;
      e.blk = rem > 0;
      q.push_back(e);
   endtask : send

   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task conclude;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   // ****************************************
   // Monitor
   // ****************************************
   always @(posedge sys_clk) pend <= instr_valid;
   always @(negedge sys_clk) begin
      if (wb_pend) begin
         chk("dst_loc", wb_exp, dst_loc);
      end
      wb_pend = 0;
      if (pend && q.size() > 0) begin
         m = q.pop_front();
         chk("op_class", m.cl, op_class);
         chk("wr_en", m.we, wr_en);
         if (m.we) begin
            chk("wr_data", m.wd, wr_data);
            chk("flags", m.fl[7:2], flags_out[7:2]);
         end
         chk("branch_target", m.bt, branch_target);
         chk("branch_en", m.be, branch_en);
         chk("index_addr", m.ia, index_addr);
         chk("wpair_ok", m.wo, wpair_ok);
         chk("fpair_ok", m.fo, fpair_ok);
         chk("vector_ok", 1'b1, vector_ok);
         chk("irq_dma_block", m.blk, irq_dma_block);
         wb_pend = m.we;
         wb_exp = m.wd;
      end else if (!pend) begin
         chk("idle wr_en", 1'b0, wr_en);
         chk("idle branch_en", 1'b0, branch_en);
      end
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 0;
      for (int i = 2; i < 10; i++) send(i[7:0], 9'h100);
      for (int i = 82; i < 90; i++) send(i[7:0], 9'h100);
      send(OP_ATOMIC, 9'h100);
      send(8'h04, 9'h100);
      send(OP_ATOMIC, 9'h100);
      repeat (4) send(8'h52, 9'h100);
      send(OP_BTB_LO, 9'h07f);
      send(OP_BTB_HI, 9'h080);
      send(8'h01, 9'h100);
      send(OP_BRK, 9'h100);
      send(OP_BITOP, 9'h100);
      send(OP_BIT_REVERSE, 9'h100);
      repeat (200) begin
         r = $random(seed);
         send(r[7:0], 9'h100);
         if (r[9:8] == 2'h0) begin
            @(negedge sys_clk);
            instr_valid = 0;
         end
      end
      @(negedge sys_clk);
      instr_valid = 0;
      repeat (3) @(negedge sys_clk);
      conclude();
   end

   initial begin
      #20000;
      err_count++;
      conclude();
   end
endmodule : tb_top
